//--- common/qsq_regs.vh
`ifndef QSQ_REGS_VH
`define QSQ_REGS_VH
// byte offsets on the register bus
`define QSQ_CMD_BASE 8'h00
`define QSQ_CTRL0_OFF 8'h40
`define QSQ_CTRL1_OFF 8'h44
`define QSQ_CTRL2_OFF 8'h48
`define QSQ_STAT_OFF 8'h4C
`define QSQ_TX_BASE 8'h80
`define QSQ_RX_BASE 8'hC0
// serial_control_zero fields
`define QSQ_C0_MASTER 0
`define QSQ_C0_ENABLE 1
`define QSQ_C0_SEL0_DRIVE 2
`define QSQ_C0_BITS_LSB 4
`define QSQ_C0_HALF_LSB 8
// serial_control_one fields
`define QSQ_C1_LEAD_LSB 0
`define QSQ_C1_POST_LSB 8
// serial_control_two fields
`define QSQ_C2_START_LSB 0
`define QSQ_C2_END_LSB 8
// status fields
`define QSQ_ST_FINISHED 0
`define QSQ_ST_FAULT 1
`define QSQ_ST_DONE_LSB 4
`define QSQ_ST_BUSY 8
// command byte fields
`define QSQ_CMD_HOLD 7
`define QSQ_CMD_LEN 6
`define QSQ_CMD_POST 5
`define QSQ_CMD_LEAD 4
// reset values
`define QSQ_CTRL0_RESET 16'h0400
`define QSQ_CTRL1_RESET 16'h0404
// bit counts, and timing counts in system clocks
`define QSQ_DEFAULT_BITS 5'd8
`define QSQ_FULL_BITS 5'd16
`define QSQ_STD_POST_CLK 14'd17
`define QSQ_POST_UNIT_CLK 14'd32
`define QSQ_POST_ZERO_CLK 14'd8192
`endif

//--- rtl/qsq_sync.v
`timescale 1ns/10ps
module qsq_sync #(
   parameter WIDTH = 4
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire [WIDTH-1:0] async_in,
   input wire [WIDTH-1:0] reset_level,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   // reset to the pin's idle level, so no false edge follows reset
   always @(posedge clk_sys) begin
      if (rst) begin
         stage1 <= reset_level;
         sync_out <= reset_level;
      end else if (ce) begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // qsq_sync

//--- rtl/qsq_delay.v
`timescale 1ns/10ps
module qsq_delay #(
   parameter WIDTH = 14
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire start,
   input wire [WIDTH-1:0] length,
   output wire done
);
   reg [WIDTH-1:0] count;
   always @(posedge clk_sys) begin
      if (rst) begin
         count <= {WIDTH{1'b0}};
      end else if (ce) begin
         if (start) begin
            count <= length;
         end else if (count != {WIDTH{1'b0}}) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
   // pulses in the last counted cycle, so the caller moves on exactly on time
   assign done = ce && !start && (count == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // qsq_delay

//--- rtl/qsq_top.v
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "qsq_regs.vh"
module qsq_top #(
   parameter DATA_W = 16
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire sck_in,
   output reg sck_out,
   output wire sck_oe,
   input wire mosi_in,
   output wire mosi_out,
   output wire mosi_oe,
   input wire miso_in,
   output wire miso_out,
   output wire miso_oe,
   input wire select0_or_slave_select_in,
   output wire [3:0] sel_out,
   output wire [3:0] sel_oe,
   input wire [3:0] port_sel_level,
   input wire [3:0] port_sel_dir
);
   localparam ST_IDLE = 3'd0;
   localparam ST_LOAD = 3'd1;
   localparam ST_LEAD = 3'd2;
   localparam ST_LOW = 3'd3;
   localparam ST_HIGH = 3'd4;
   localparam ST_POST = 3'd5;
   localparam ST_SLV = 3'd6;
   localparam ST_WAIT = 3'd7;
   localparam [15:0] CTRL0_RST = `QSQ_CTRL0_RESET;
   localparam [15:0] CTRL1_RST = `QSQ_CTRL1_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function [4:0] xfer_len;
      input sel;
      input [3:0] bits;
      begin
         if (!sel) begin
            xfer_len = `QSQ_DEFAULT_BITS;
         end else if (bits == 4'h0) begin
            xfer_len = `QSQ_FULL_BITS;
         end else begin
            xfer_len = {1'b0, bits};
         end
      end
   endfunction

   function [13:0] at_least_one;
      input [13:0] v;
      begin
         at_least_one = (v == 14'd0) ? 14'd1 : v;
      end
   endfunction

   function [15:0] justify;
      input [15:0] word;
      input [4:0] len;
      reg [4:0] sh;
      begin
         sh = 5'd16 - len;
         justify = word << sh;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // storage and control registers
   reg [7:0] cmd_mem [0:15];
   reg [DATA_W-1:0] tx_mem [0:15];
   reg [DATA_W-1:0] rx_mem [0:15];
   reg master_select;
   reg engine_enable;
   reg sel0_drive;
   reg [3:0] bit_count;
   reg [7:0] sck_half;
   reg [6:0] clock_lead_length;
   reg [7:0] post_delay_length;
   reg [3:0] queue_start_pointer;
   reg [3:0] queue_end_pointer;
   reg finished;
   reg mode_fault_flag;
   reg [3:0] done_ptr;

   reg [2:0] state;
   reg [3:0] ptr;
   reg queue_active;
   reg [7:0] cmd;
   reg [3:0] pattern;
   reg sel_active;
   reg [15:0] shreg;
   reg [15:0] rxreg;
   reg [4:0] bits_left;
   reg dly_start;
   reg [13:0] dly_value;
   reg finish_pulse;
   reg sck_prev;

   wire [2:0] pin_sync;
   wire sck_s = pin_sync[2];
   wire mosi_s = pin_sync[1];
   wire miso_s = pin_sync[0];
   wire ss_s;
   wire dly_done;
   integer i;
   integer j;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and delay counter
   qsq_sync #(.WIDTH(3)) u_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .async_in({sck_in, mosi_in, miso_in}),
      .reset_level(3'h0),
      .sync_out(pin_sync)
   );

   qsq_sync #(.WIDTH(1)) u_ss_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .async_in(select0_or_slave_select_in),
      .reset_level(1'b1),
      .sync_out(ss_s)
   );

   qsq_delay #(.WIDTH(14)) u_delay (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .start(dly_start),
      .length(dly_value),
      .done(dly_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   wire setup = psel && !penable;
   wire wr_go = psel && penable && pwrite;
   wire in_cmd = (paddr[7:6] == 2'b00);
   wire in_tx = (paddr[7:6] == 2'b10);
   wire in_rx = (paddr[7:6] == 2'b11);
   wire in_ctrl = (paddr == `QSQ_CTRL0_OFF) || (paddr == `QSQ_CTRL1_OFF) ||
      (paddr == `QSQ_CTRL2_OFF) || (paddr == `QSQ_STAT_OFF);
   wire mapped = in_cmd || in_tx || in_rx || in_ctrl;
   wire [3:0] idx = paddr[5:2];
   wire fault_now = master_select && engine_enable && !sel0_drive && !ss_s;
   // fault watched in master mode while sel0_drive is clear; between selects port_sel_dir can still drive pin zero and trip it

   assign pready = 1'b1;

   always @(posedge clk_sys) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (ce && setup) begin
         prdata <= 32'h00000000;
         pslverr <= !mapped;
         if (in_cmd) begin
            prdata <= {24'h000000, cmd_mem[idx]};
         end else if (in_tx) begin
            prdata <= {{(32-DATA_W){1'b0}}, tx_mem[idx]};
         end else if (in_rx) begin
            prdata <= {{(32-DATA_W){1'b0}}, rx_mem[idx]};
         end else if (paddr == `QSQ_CTRL0_OFF) begin
            prdata <= {16'h0000, sck_half, bit_count, 1'b0, sel0_drive,
               engine_enable, master_select};
         end else if (paddr == `QSQ_CTRL1_OFF) begin
            prdata <= {16'h0000, post_delay_length, 1'b0, clock_lead_length};
         end else if (paddr == `QSQ_CTRL2_OFF) begin
            prdata <= {20'h00000, queue_end_pointer, 4'h0, queue_start_pointer};
         end else if (paddr == `QSQ_STAT_OFF) begin
            prdata <= {23'h000000, queue_active, done_ptr, 2'b00,
               mode_fault_flag, finished};
         end
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         for (j = 0; j < 16; j = j + 1) begin
            cmd_mem[j] <= 8'h00;
            tx_mem[j] <= {DATA_W{1'b0}};
         end
         sck_half <= CTRL0_RST[15:8];
         bit_count <= CTRL0_RST[7:4];
         master_select <= 1'b0;
         engine_enable <= 1'b0;
         sel0_drive <= 1'b0;
         clock_lead_length <= CTRL1_RST[6:0];
         post_delay_length <= CTRL1_RST[15:8];
         queue_start_pointer <= 4'h0;
         queue_end_pointer <= 4'h0;
         finished <= 1'b0;
         mode_fault_flag <= 1'b0;
      end else if (ce) begin
         if (wr_go && in_cmd) begin
            cmd_mem[idx] <= pwdata[7:0];
         end
         if (wr_go && in_tx) begin
            tx_mem[idx] <= pwdata[DATA_W-1:0];
         end
         if (wr_go && paddr == `QSQ_CTRL0_OFF) begin
            master_select <= pwdata[`QSQ_C0_MASTER];
            engine_enable <= pwdata[`QSQ_C0_ENABLE];
            sel0_drive <= pwdata[`QSQ_C0_SEL0_DRIVE];
            bit_count <= pwdata[`QSQ_C0_BITS_LSB +: 4];
            sck_half <= pwdata[`QSQ_C0_HALF_LSB +: 8];
         end else if (finish_pulse) begin
            engine_enable <= 1'b0;
         end
         if (wr_go && paddr == `QSQ_CTRL1_OFF) begin
            clock_lead_length <= pwdata[`QSQ_C1_LEAD_LSB +: 7];
            post_delay_length <= pwdata[`QSQ_C1_POST_LSB +: 8];
         end
         if (wr_go && paddr == `QSQ_CTRL2_OFF) begin
            queue_start_pointer <= pwdata[`QSQ_C2_START_LSB +: 4];
            queue_end_pointer <= pwdata[`QSQ_C2_END_LSB +: 4];
         end
         // hardware set beats a same-cycle write-one clear
         if (finish_pulse) begin
            finished <= 1'b1;
         end else if (wr_go && paddr == `QSQ_STAT_OFF && pwdata[`QSQ_ST_FINISHED]) begin
            finished <= 1'b0;
         end
         if (fault_now) begin
            mode_fault_flag <= 1'b1;
         end else if (wr_go && paddr == `QSQ_STAT_OFF && pwdata[`QSQ_ST_FAULT]) begin
            mode_fault_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // queue engine
   wire [7:0] cur_cmd = cmd_mem[ptr];
   wire [4:0] cur_len = xfer_len(cur_cmd[`QSQ_CMD_LEN], bit_count);
   wire [4:0] slv_len = xfer_len(1'b1, bit_count);
   wire [13:0] half_clk = at_least_one({6'h00, sck_half});
   wire [13:0] lead_clk = cur_cmd[`QSQ_CMD_LEAD] ?
      at_least_one({7'h00, clock_lead_length}) : half_clk;
   wire [13:0] post_clk = !cmd[`QSQ_CMD_POST] ? `QSQ_STD_POST_CLK :
      (post_delay_length == 8'h00) ? `QSQ_POST_ZERO_CLK :
      `QSQ_POST_UNIT_CLK * {6'h00, post_delay_length};
   wire sck_rise = sck_s && !sck_prev;
   wire sck_fall = !sck_s && sck_prev;

   always @(posedge clk_sys) begin
      if (rst) begin
         state <= ST_IDLE;
         ptr <= 4'h0;
         queue_active <= 1'b0;
         cmd <= 8'h00;
         pattern <= 4'h0;
         sel_active <= 1'b0;
         shreg <= 16'h0000;
         rxreg <= 16'h0000;
         bits_left <= 5'd0;
         dly_start <= 1'b0;
         dly_value <= 14'd1;
         finish_pulse <= 1'b0;
         sck_out <= 1'b0;
         sck_prev <= 1'b0;
         done_ptr <= 4'h0;
         for (i = 0; i < 16; i = i + 1) begin
            rx_mem[i] <= {DATA_W{1'b0}};
         end
      end else if (ce) begin
         dly_start <= 1'b0;
         finish_pulse <= 1'b0;
         sck_prev <= sck_s;
         if (!engine_enable) begin
            state <= ST_IDLE;
            queue_active <= 1'b0;
            sel_active <= 1'b0;
            sck_out <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (!queue_active) begin
                     ptr <= queue_start_pointer;
                     queue_active <= 1'b1;
                  end else if (master_select) begin
                     state <= ST_LOAD;
                  end else if (!ss_s) begin
                     shreg <= justify(tx_mem[ptr], slv_len);
                     rxreg <= 16'h0000;
                     bits_left <= slv_len;
                     state <= ST_SLV;
                  end
               end
               ST_LOAD: begin
                  cmd <= cur_cmd;
                  pattern <= cur_cmd[3:0];
                  sel_active <= 1'b1;
                  shreg <= justify(tx_mem[ptr], cur_len);
                  rxreg <= 16'h0000;
                  bits_left <= cur_len;
                  dly_value <= lead_clk;
                  dly_start <= 1'b1;
                  state <= ST_LEAD;
               end
               ST_LEAD: begin
                  // lead wait already spaces select from the first edge
                  if (dly_done) begin
                     sck_out <= 1'b1;
                     rxreg <= {rxreg[14:0], miso_s};
                     dly_value <= half_clk;
                     dly_start <= 1'b1;
                     state <= ST_HIGH;
                  end
               end
               ST_LOW: begin
                  if (dly_done) begin
                     sck_out <= 1'b1;
                     rxreg <= {rxreg[14:0], miso_s};
                     dly_value <= half_clk;
                     dly_start <= 1'b1;
                     state <= ST_HIGH;
                  end
               end
               ST_HIGH: begin
                  if (dly_done) begin
                     sck_out <= 1'b0;
                     shreg <= {shreg[14:0], 1'b0};
                     bits_left <= bits_left - 5'd1;
                     dly_start <= 1'b1;
                     if (bits_left == 5'd1) begin
                        dly_value <= post_clk;
                        state <= ST_POST;
                     end else begin
                        dly_value <= half_clk;
                        state <= ST_LOW;
                     end
                  end
               end
               ST_SLV: begin
                  if (sck_rise) begin
                     rxreg <= {rxreg[14:0], mosi_s};
                     bits_left <= bits_left - 5'd1;
                  end else if (sck_fall) begin
                     shreg <= {shreg[14:0], 1'b0};
                  end
                  // a select released early ends the entry with partial data
                  if (ss_s || (sck_fall && bits_left == 5'd0)) begin
                     cmd <= 8'h00;
                     dly_value <= 14'd1;
                     dly_start <= 1'b1;
                     state <= ST_POST;
                  end
               end
               ST_POST: begin
                  if (dly_done) begin
                     rx_mem[ptr] <= rxreg[DATA_W-1:0];
                     done_ptr <= ptr;
                     if (!cmd[`QSQ_CMD_HOLD]) begin
                        sel_active <= 1'b0;
                     end
                     if (ptr == queue_end_pointer) begin
                        finish_pulse <= 1'b1;
                        queue_active <= 1'b0;
                     end else begin
                        ptr <= ptr + 4'h1;
                     end
                     state <= master_select ? ST_LOAD : ST_WAIT;
                     if (ptr == queue_end_pointer) begin
                        state <= ST_WAIT;
                     end
                  end
               end
               ST_WAIT: begin
                  if (ss_s || master_select) begin
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins
   wire drv_master = engine_enable && master_select;
   wire slave_sel = engine_enable && !master_select && !ss_s;
   assign sck_oe = drv_master;
   assign mosi_out = shreg[15];
   assign mosi_oe = drv_master;
   assign miso_out = shreg[15];
   assign miso_oe = slave_sel;
   assign sel_out = (drv_master && sel_active) ? pattern : port_sel_level;
   // slave mode drives no select pattern; selects one to three follow port_sel_dir, pin zero stays an input there
   assign sel_oe = (drv_master && sel_active) ? {3'b111, sel0_drive} :
      (!master_select && engine_enable) ? (port_sel_dir & 4'hE) : port_sel_dir;
endmodule // qsq_top

//--- sim/qsq_chk.sv
`timescale 1ns/10ps
module qsq_chk (
   input wire clk_sys,
   input wire rst,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pslverr,
   input wire sck_out,
   input wire sck_oe,
   input wire mosi_out,
   input wire mosi_oe,
   input wire miso_oe,
   input wire select0_or_slave_select_in,
   input wire [3:0] sel_out,
   input wire [3:0] sel_oe,
   input wire [3:0] port_sel_level,
   input wire [3:0] port_sel_dir
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////////////////
   chk_cmd_mapped: assert property (psel && !penable && paddr[7:6] == 2'b00 |=> !pslverr)
      else $error("command entry access refused");
   chk_unmapped_err: assert property (psel && !penable && paddr[7:4] == 4'h5 |=> pslverr)
      else $error("unmapped access not refused");
   chk_drivers_paired: assert property (mosi_oe == sck_oe)
      else $error("data and clock drivers disagree");
   chk_oe_exclusive: assert property (miso_oe |-> !mosi_oe && !sck_oe)
      else $error("slave and master drivers together");
   chk_slave_no_sel: assert property (!sck_oe |-> sel_out == port_sel_level)
      else $error("selects driven outside master mode");
   chk_slave_dir: assert property (!sck_oe |-> sel_oe[3:1] == port_sel_dir[3:1])
      else $error("select enables not returned to port");
   chk_sel_steady: assert property (sck_oe && sck_out |-> $stable(sel_out))
      else $error("selects moved during serial clock high");
   chk_mosi_steady: assert property (sck_oe && sck_out && $past(sck_out) |-> $stable(mosi_out))
      else $error("data out moved while clock high");
   chk_slave_idle: assert property (select0_or_slave_select_in [*5] |-> !miso_oe)
      else $error("slave output without select");
   chk_sck_master: assert property (sck_out && !$past(sck_out) |-> sck_oe)
      else $error("serial clock edge outside master mode");
endmodule // qsq_chk
bind qsq_top qsq_chk u_chk (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
   .penable(penable), .pslverr(pslverr), .sck_out(sck_out), .sck_oe(sck_oe),
   .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
   .select0_or_slave_select_in(select0_or_slave_select_in), .sel_out(sel_out),
   .sel_oe(sel_oe), .port_sel_level(port_sel_level), .port_sel_dir(port_sel_dir));

//--- sim/qsq_peer.sv
`timescale 1ns/10ps
module qsq_peer (
   input wire clk_sys,
   input wire [3:0] sel_out,
   input wire sck_out,
   input wire mosi_out,
   input wire ss_pull,
   output wire miso_line,
   output wire ss_line
);
   localparam [15:0] REPLY = 16'hB2D4;
   reg [15:0] log_word [0:3];
   reg [4:0] log_bits [0:3];
   reg [3:0] log_sel [0:3];
   reg [1:0] frame = 2'd0;
   reg [15:0] shift_in = 16'h0000;
   reg [4:0] rise_cnt = 5'd0;
   reg [3:0] fall_cnt = 4'd0;
   reg [3:0] sel_q = 4'h0;
   reg sck_d = 1'b0;
   reg busy = 1'b0;
   // pin has a pull-up; a competing master pulls it low
   assign ss_line = ss_pull ? 1'b0 : 1'b1;
   // released line shows the inverse, so a stale bit is never mistaken for data
   assign miso_line = busy ? REPLY[~fall_cnt] : ~REPLY[~fall_cnt];
   ////////////////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      sck_d <= sck_out;
      sel_q <= sel_out;
      busy <= |sel_out;
      if (busy && sel_out != sel_q) begin
         log_word[frame] <= shift_in;
         log_bits[frame] <= rise_cnt;
         log_sel[frame] <= sel_q;
         frame <= frame + 2'd1;
         shift_in <= 16'h0000;
         rise_cnt <= 5'd0;
         fall_cnt <= 4'd0;
      end else if (busy) begin
         if (sck_out && !sck_d) begin
            shift_in <= {shift_in[14:0], mosi_out};
            rise_cnt <= rise_cnt + 5'd1;
         end
         // mode 0: next bit presented after the falling edge
         if (!sck_out && sck_d) begin
            fall_cnt <= fall_cnt + 4'd1;
         end
      end
   end
endmodule // qsq_peer

//--- sim/testbench.sv
`timescale 1ns/10ps
`include "qsq_regs.vh"
module testbench;
   reg clk_sys = 1'b0;
   reg rst = 1'b1;
   reg [7:0] paddr = 8'h00;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [31:0] pwdata = 32'h0000_0000;
   reg ss_pull = 1'b0;
   reg sck_drv = 1'b0;
   reg mosi_drv = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   wire miso_line, ss_line;
   wire [3:0] sel_out, sel_oe;
   integer fails = 0;
   integer comparisons = 0;
   integer n;
   reg [31:0] rd;
   reg err;
   reg [7:0] slv_seen;
   reg [7:0] slv_oe;
   qsq_top u_qsq_top (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_in(sck_drv), .sck_out(sck_out), .sck_oe(sck_oe),
      .mosi_in(mosi_drv),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_line), .miso_out(miso_out),
      .miso_oe(miso_oe), .select0_or_slave_select_in(ss_line), .sel_out(sel_out),
      .sel_oe(sel_oe), .port_sel_level(4'h0), .port_sel_dir(4'hF));
   qsq_peer u_qsq_peer (.clk_sys(clk_sys), .sel_out(sel_out), .sck_out(sck_out),
      .mosi_out(mosi_out), .ss_pull(ss_pull), .miso_line(miso_line), .ss_line(ss_line));
   ////////////////////////////////////////////////////////////////////////////////////////////
   task check(input [8*12-1:0] what, input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d fails %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask
   // one transfer; no wait count assumed, only a bound against a hang
   task apb(input wr, input [7:0] addr, input [31:0] data);
      integer k;
      begin
         k = 0;
         @(posedge clk_sys);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= addr;
         pwdata <= data;
         @(posedge clk_sys);
         penable <= 1'b1;
         @(posedge clk_sys);
         while (pready !== 1'b1 && k < 20) begin
            k = k + 1;
            @(posedge clk_sys);
         end
         if (k == 20) begin
            fails = fails + 1;
            give_verdict;
         end
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rchk(input [8*12-1:0] what, input [7:0] addr, input [31:0] exp);
      begin
         apb(1'b0, addr, 32'h0);
         check(what, rd, exp);
      end
   endtask
   // external master, mode 0: 160 ns serial clock, select low for the frame
   task slave_xfer(input [7:0] word);
      integer b;
      begin
         ss_pull <= 1'b1;
         for (b = 7; b >= 0; b = b - 1) begin
            mosi_drv <= word[b];
            repeat (20) @(posedge clk_sys);
            sck_drv <= 1'b1;
            slv_seen = {slv_seen[6:0], miso_out};
            slv_oe = {slv_oe[6:0], miso_oe && sel_oe == 4'hE};
            repeat (20) @(posedge clk_sys);
            sck_drv <= 1'b0;
         end
         repeat (20) @(posedge clk_sys);
         ss_pull <= 1'b0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rchk("ctrl0", `QSQ_CTRL0_OFF, 32'h0000_0400);
      rchk("ctrl1", `QSQ_CTRL1_OFF, 32'h0000_0404);
      rchk("ctrl2", `QSQ_CTRL2_OFF, 32'h0000_0000);
      apb(1'b0, 8'h50, 32'h0);
      check("unmapped", {rd[30:0], err}, 32'h1);
      $display("test reset done");
      // upper bits of a command word must not stick
      for (n = 0; n < 16; n = n + 1) apb(1'b1, 8'(4 * n), {24'hABCDEF, 8'(n * 17) ^ 8'h3C});
      for (n = 0; n < 16; n = n + 1) rchk("cmd", 8'(4 * n), {24'h0, 8'(n * 17) ^ 8'h3C});
      $display("test command memory done");
      apb(1'b1, 8'h08, 32'h0A);
      apb(1'b1, 8'h0C, 32'h75);
      apb(1'b1, 8'h88, 32'hA5);
      apb(1'b1, 8'h8C, 32'h3C6);
      apb(1'b1, `QSQ_CTRL1_OFF, 32'h0103);
      apb(1'b1, `QSQ_CTRL2_OFF, 32'h0302);
      // half period field 20 gives 21-clock halves, a 168 ns serial clock
      apb(1'b1, `QSQ_CTRL0_OFF, 32'h14C7);
      n = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && n < 1000) begin
         n = n + 1;
         apb(1'b0, `QSQ_STAT_OFF, 32'h0);
      end
      if (n == 1000) begin
         fails = fails + 1;
         give_verdict;
      end
      rchk("status", `QSQ_STAT_OFF, 32'h31);
      rchk("ctrl0 done", `QSQ_CTRL0_OFF, 32'h14C5);
      rchk("rx 8 bit", 8'hC8, 32'hB2);
      rchk("rx 12 bit", 8'hCC, 32'hB2D);
      rchk("cmd kept", 8'h08, 32'h0A);
      rchk("cmd kept", 8'h0C, 32'h75);
      check("mosi 8 bit", {16'h0, u_qsq_peer.log_word[0]}, 32'hA5);
      check("mosi 12 bit", {16'h0, u_qsq_peer.log_word[1]}, 32'h3C6);
      check("bits", {u_qsq_peer.log_bits[0], u_qsq_peer.log_bits[1]}, 32'h10C);
      check("selects", {u_qsq_peer.log_sel[0], u_qsq_peer.log_sel[1]}, 32'hA5);
      $display("test master queue done");
      apb(1'b1, `QSQ_STAT_OFF, 32'h1);
      @(posedge clk_sys);
      ss_pull <= 1'b1;
      apb(1'b1, `QSQ_CTRL2_OFF, 32'h0);
      apb(1'b1, `QSQ_CTRL0_OFF, 32'h1403);
      rchk("fault", `QSQ_STAT_OFF, 32'h132);
      check("drivers", {30'h0, mosi_oe, sck_oe}, 32'h3);
      rchk("ctrl0 fault", `QSQ_CTRL0_OFF, 32'h1403);
      apb(1'b1, `QSQ_CTRL0_OFF, 32'h1400);
      ss_pull <= 1'b0;
      apb(1'b1, `QSQ_STAT_OFF, 32'h2);
      apb(1'b0, `QSQ_STAT_OFF, 32'h0);
      check("fault clr", {30'h0, rd[1:0]}, 32'h0);
      check("off", {30'h0, mosi_oe, sck_oe}, 32'h0);
      $display("test mode fault done");
      apb(1'b1, 8'h90, 32'h5A);
      apb(1'b1, `QSQ_CTRL2_OFF, 32'h0404);
      apb(1'b1, `QSQ_CTRL0_OFF, 32'h1482);
      slave_xfer(8'hC3);
      check("slave miso", {24'h0, slv_seen}, 32'h5A);
      check("slave oe", {24'h0, slv_oe}, 32'hFF);
      rchk("slave rx", 8'hD0, 32'hC3);
      rchk("slave stat", `QSQ_STAT_OFF, 32'h41);
      $display("test slave done");
      give_verdict;
   end
endmodule // testbench
